// ---- design/spb_params.svh ----
// How it works
// RULE1 - bit 3 of preamble flags marks a compressed-surround CD preamble.
// RULE2 - bit 2 of preamble flags shows the frame is nonaudio data.
// RULE3 - bit 1 of preamble flags shows subframe A carries nonaudio data.
// RULE4 - bit 0 of preamble flags shows subframe B carries nonaudio data.
// RULE5 - receive channel status is 24 bytes at 0x20 to 0x37, pro bit first.
// RULE6 - host writes receive status only while status autobuffer runs.
// RULE7 - transmit channel status is 24 bytes at 0x38 to 0x4F, pro bit first.
// RULE8 - status autobuffer sends receiver status, not host transmit status.
// RULE9 - register 0x50 points into the receive user buffer.
// RULE10 - reading 0x51 returns the receive user byte at that pointer.
// RULE11 - receive user buffer is writable only while user autobuffer runs.
// RULE12 - register 0x52 points into the transmit user buffer.
// RULE13 - writing 0x53 stores a byte in the transmit user buffer at pointer.
// RULE14 - user autobuffer disables the host transmit user buffer.
// RULE15 - check failure sets 0x54 bit 1 until read, without interrupt.
// RULE16 - 0x54 bit 0 sets once a whole subcode is loaded.
// RULE17 - ten read-only subcode bytes sit at 0x55 to 0x5E.
// RULE18 - byte 0x55 holds address nibble high and control nibble low.
// RULE19 - reserved status bits read zero and ignore writes.
`ifndef SPB_PARAMS_SVH
`define SPB_PARAMS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPB_IDX_PRE 7'h1F
`define SPB_IDX_RXCS 7'h20
`define SPB_IDX_RXCS_END 7'h37
`define SPB_IDX_TXCS 7'h38
`define SPB_IDX_TXCS_END 7'h4F
`define SPB_IDX_RXPTR 7'h50
`define SPB_IDX_RXUB 7'h51
`define SPB_IDX_TXPTR 7'h52
`define SPB_IDX_TXUB 7'h53
`define SPB_IDX_QSTAT 7'h54
`define SPB_IDX_QBUF 7'h55
`define SPB_IDX_QBUF_END 7'h5E
`define SPB_IDX_ISTAT 7'h60
`define SPB_IDX_IMASK 7'h61
// ----------------------------------------------------------------
// fields and sizes
// ----------------------------------------------------------------
`define SPB_PRE_SURR 3
`define SPB_PRE_FRAME 2
`define SPB_PRE_SUBA 1
`define SPB_PRE_SUBB 0
`define SPB_QS_FAIL 1
`define SPB_QS_LOAD 0
`define SPB_IRQ_QLOAD 0
`define SPB_IRQ_CSBLK 1
`define SPB_IRQ_UBNEW 2
`define SPB_CS_BYTES 24
`define SPB_Q_BYTES 10
`define SPB_UB_BYTES 256
`define SPB_RESP_OKAY 2'h0
`define SPB_RESP_SLVERR 2'h2
`define SPB_ZERO8 8'h00
`endif

// ---- design/spb_pkg.sv ----
`include "spb_params.svh"
package spb_pkg;
  typedef struct packed {
    logic awv;
    logic [6:0] awa;
    logic wv;
    logic [7:0] wd;
    logic ws;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [3:0] pre;
    logic [`SPB_CS_BYTES-1:0][7:0] rx_cs;
    logic [`SPB_CS_BYTES-1:0][7:0] tx_cs;
    logic [7:0] rx_ptr;
    logic [7:0] tx_ptr;
    logic [`SPB_UB_BYTES-1:0][7:0] rx_ub;
    logic [`SPB_UB_BYTES-1:0][7:0] tx_ub;
    logic qfail;
    logic qload;
    logic [`SPB_Q_BYTES-1:0][7:0] qbuf;
    logic [2:0] istat;
    logic [2:0] imask;
    logic [7:0] tx_cs_o;
    logic [7:0] tx_ub_o;
  } spb_state_s;
endpackage

// ---- design/spb_top.sv ----
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "spb_params.svh"
module spb_top
  import spb_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // axi4-lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [8:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // axi4-lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // axi4-lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [8:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // axi4-lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // interrupt
  output logic IRQ,
  // autobuffer enables
  input wire logic CS_AUTOBUF,
  input wire logic UB_AUTOBUF,
  // receiver frame decoder
  input wire logic SURR_CD_PREAMBLE_FLAG,
  input wire logic NONAUDIO_FRAME,
  input wire logic NONAUDIO_SUBFRAME_A,
  input wire logic NONAUDIO_SUBFRAME_B,
  input wire logic RX_CS_WE,
  input wire logic [4:0] RX_CS_IDX,
  input wire logic [7:0] RX_CS_DATA,
  input wire logic RX_CS_BLOCK_DONE,
  input wire logic RX_UB_WE,
  input wire logic [7:0] RX_UB_ADDR,
  input wire logic [7:0] RX_UB_DATA,
  // transmitter readout
  input wire logic [4:0] TX_CS_IDX,
  output logic [7:0] TX_CS_BYTE,
  input wire logic [7:0] TX_UB_ADDR,
  output logic [7:0] TX_UB_BYTE,
  // subcode checker
  input wire logic Q_LOAD,
  input wire logic [3:0] Q_ADDR_NIB,
  input wire logic [3:0] Q_CTRL_NIB,
  input wire logic [71:0] Q_REST,
  input wire logic Q_CRC_FAIL
);

  spb_state_s q;
  spb_state_s d;
  logic wr_fire;
  logic rd_fire;
  logic [6:0] ar_idx;
  logic [4:0] w_cs_off;
  logic [4:0] r_cs_off;
  logic [3:0] r_q_off;
  logic [2:0] ev;
  logic [2:0] clr;
  logic wr_ok;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign AWREADY = !q.awv;
  assign WREADY = !q.wv;
  assign ARREADY = !q.rv;
  assign BVALID = q.bv;
  assign BRESP = q.bresp;
  assign RVALID = q.rv;
  assign RDATA = {24'h000000, q.rdata};
  assign RRESP = q.rresp;
  assign IRQ = |(q.istat & q.imask);
  assign TX_CS_BYTE = q.tx_cs_o;
  assign TX_UB_BYTE = q.tx_ub_o;
  assign wr_fire = q.awv && q.wv && !q.bv;
  assign rd_fire = ARVALID && !q.rv;
  assign ar_idx = ARADDR[8:2];
  assign w_cs_off = (q.awa >= `SPB_IDX_TXCS) ?
    5'(q.awa - `SPB_IDX_TXCS) : 5'(q.awa - `SPB_IDX_RXCS);
  assign r_cs_off = (ar_idx >= `SPB_IDX_TXCS) ?
    5'(ar_idx - `SPB_IDX_TXCS) : 5'(ar_idx - `SPB_IDX_RXCS);
  assign r_q_off = 4'(ar_idx - `SPB_IDX_QBUF);
  assign wr_ok = wr_fire && q.ws;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    ev = 3'h0;
    clr = 3'h0;
    if (AWVALID && !q.awv)
    begin
      d.awv = 1'b1;
      d.awa = AWADDR[8:2];
    end
    if (WVALID && !q.wv)
    begin
      d.wv = 1'b1;
      d.wd = WDATA[7:0];
      d.ws = WSTRB[0];
    end
    if (q.bv && BREADY)
      d.bv = 1'b0;
    // write decode; read-only targets answer okay and keep their value
    if (wr_fire)
    begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bv = 1'b1;
      d.bresp = `SPB_RESP_OKAY;
      if (q.awa >= `SPB_IDX_RXCS && q.awa <= `SPB_IDX_RXCS_END)
      begin
        if (q.ws && CS_AUTOBUF) // RULE6
          d.rx_cs[w_cs_off] = q.wd;
      end
      else if (q.awa >= `SPB_IDX_TXCS && q.awa <= `SPB_IDX_TXCS_END)
      begin
        if (q.ws && !CS_AUTOBUF) // RULE8
          d.tx_cs[w_cs_off] = q.wd;
      end
      else if (q.awa == `SPB_IDX_RXPTR)
      begin
        if (q.ws)
          d.rx_ptr = q.wd; // RULE9
      end
      else if (q.awa == `SPB_IDX_RXUB)
      begin
        if (q.ws && UB_AUTOBUF) // RULE11
          d.rx_ub[q.rx_ptr] = q.wd;
      end
      else if (q.awa == `SPB_IDX_TXPTR)
      begin
        if (q.ws)
          d.tx_ptr = q.wd; // RULE12
      end
      else if (q.awa == `SPB_IDX_TXUB)
      begin
        if (q.ws && !UB_AUTOBUF) // RULE13 RULE14
          d.tx_ub[q.tx_ptr] = q.wd;
      end
      else if (q.awa == `SPB_IDX_ISTAT)
      begin
        if (q.ws)
          clr = q.wd[2:0];
      end
      else if (q.awa == `SPB_IDX_IMASK)
      begin
        if (q.ws)
          d.imask = q.wd[2:0];
      end
      else if (q.awa == `SPB_IDX_PRE || q.awa == `SPB_IDX_QSTAT ||
               (q.awa >= `SPB_IDX_QBUF && q.awa <= `SPB_IDX_QBUF_END))
        d.bresp = `SPB_RESP_OKAY; // RULE19
      else
        d.bresp = `SPB_RESP_SLVERR;
    end
    if (q.rv && RREADY)
      d.rv = 1'b0;
    // read decode; the status clear happens when the read is taken
    if (rd_fire)
    begin
      d.rv = 1'b1;
      d.rresp = `SPB_RESP_OKAY;
      d.rdata = `SPB_ZERO8;
      if (ar_idx == `SPB_IDX_PRE)
        d.rdata = {4'h0, q.pre}; // RULE19
      else if (ar_idx >= `SPB_IDX_RXCS && ar_idx <= `SPB_IDX_RXCS_END)
        d.rdata = q.rx_cs[r_cs_off]; // RULE5
      else if (ar_idx >= `SPB_IDX_TXCS && ar_idx <= `SPB_IDX_TXCS_END)
        d.rdata = q.tx_cs[r_cs_off]; // RULE7
      else if (ar_idx == `SPB_IDX_RXPTR)
        d.rdata = q.rx_ptr;
      else if (ar_idx == `SPB_IDX_RXUB)
        d.rdata = q.rx_ub[q.rx_ptr]; // RULE10
      else if (ar_idx == `SPB_IDX_TXPTR)
        d.rdata = q.tx_ptr;
      else if (ar_idx == `SPB_IDX_TXUB)
        d.rdata = `SPB_ZERO8;
      else if (ar_idx == `SPB_IDX_QSTAT)
      begin
        d.rdata = {6'h00, q.qfail, q.qload}; // RULE19
        d.qfail = 1'b0; // RULE15
        d.qload = 1'b0;
      end
      else if (ar_idx >= `SPB_IDX_QBUF && ar_idx <= `SPB_IDX_QBUF_END)
        d.rdata = q.qbuf[r_q_off]; // RULE17
      else if (ar_idx == `SPB_IDX_ISTAT)
        d.rdata = {5'h00, q.istat};
      else if (ar_idx == `SPB_IDX_IMASK)
        d.rdata = {5'h00, q.imask};
      else
        d.rresp = `SPB_RESP_SLVERR;
    end
    // link-side events come last so a set beats a same-cycle clear
    d.pre[`SPB_PRE_SURR] = SURR_CD_PREAMBLE_FLAG; // RULE1
    d.pre[`SPB_PRE_FRAME] = NONAUDIO_FRAME; // RULE2
    d.pre[`SPB_PRE_SUBA] = NONAUDIO_SUBFRAME_A; // RULE3
    d.pre[`SPB_PRE_SUBB] = NONAUDIO_SUBFRAME_B; // RULE4
    // receiver beats a host write to the same byte
    if (RX_CS_WE && RX_CS_IDX < 5'(`SPB_CS_BYTES))
      d.rx_cs[RX_CS_IDX] = RX_CS_DATA; // RULE5
    if (RX_CS_BLOCK_DONE)
      ev[`SPB_IRQ_CSBLK] = 1'b1;
    if (RX_UB_WE)
    begin
      d.rx_ub[RX_UB_ADDR] = RX_UB_DATA;
      ev[`SPB_IRQ_UBNEW] = 1'b1;
    end
    if (Q_LOAD)
    begin
      d.qbuf = {Q_REST, Q_ADDR_NIB, Q_CTRL_NIB}; // RULE17 RULE18
      d.qload = 1'b1; // RULE16
      ev[`SPB_IRQ_QLOAD] = 1'b1;
    end
    // check failure is deliberately kept out of the interrupt
    if (Q_CRC_FAIL)
      d.qfail = 1'b1; // RULE15
    d.istat = (q.istat & ~clr) | ev;
    // transmit readout; out-of-range index reads zero
    d.tx_cs_o = `SPB_ZERO8;
    if (TX_CS_IDX < 5'(`SPB_CS_BYTES))
      d.tx_cs_o = CS_AUTOBUF ? q.rx_cs[TX_CS_IDX] :
        q.tx_cs[TX_CS_IDX]; // RULE8
    d.tx_ub_o = UB_AUTOBUF ? q.rx_ub[TX_UB_ADDR] :
      q.tx_ub[TX_UB_ADDR]; // RULE14
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_host_wr(logic [6:0] idx);
    wr_ok && q.awa == idx;
  endsequence

  sequence s_host_rd(logic [6:0] idx);
    rd_fire && ar_idx == idx;
  endsequence

  chk_pre_flags: assert property ( // RULE1 RULE2 RULE3 RULE4
    ##1 q.pre == $past({SURR_CD_PREAMBLE_FLAG, NONAUDIO_FRAME,
                        NONAUDIO_SUBFRAME_A, NONAUDIO_SUBFRAME_B}))
    else $error("preamble flags do not follow the decoder");

  chk_rxcs_locked: assert property ( // RULE6
    s_host_wr(`SPB_IDX_RXCS) ##0 !CS_AUTOBUF && !RX_CS_WE |=>
      $stable(q.rx_cs[0]))
    else $error("receive status changed by host while locked");

  chk_txcs_source: assert property ( // RULE8
    CS_AUTOBUF && TX_CS_IDX == 5'h00 |=> TX_CS_BYTE == $past(q.rx_cs[0]))
    else $error("transmit status not taken from receiver");

  chk_rxub_read: assert property ( // RULE10
    s_host_rd(`SPB_IDX_RXUB) ##1 RVALID |->
      RDATA[7:0] == $past(q.rx_ub[q.rx_ptr]))
    else $error("receive user byte read from wrong place");

  chk_txub_store: assert property ( // RULE13
    s_host_wr(`SPB_IDX_TXUB) ##0 !UB_AUTOBUF |=>
      q.tx_ub[$past(q.tx_ptr)] == $past(q.wd))
    else $error("transmit user byte not stored");

  chk_txub_locked: assert property ( // RULE14
    s_host_wr(`SPB_IDX_TXUB) ##0 UB_AUTOBUF |=> $stable(q.tx_ub))
    else $error("transmit user buffer written during autobuffer");

  chk_fail_sticky: assert property ( // RULE15
    Q_CRC_FAIL ##1 !(rd_fire && ar_idx == `SPB_IDX_QSTAT) [*2] |->
      q.qfail)
    else $error("check failure flag lost before read");

  chk_fail_noirq: assert property ( // RULE15
    Q_CRC_FAIL && q.istat == 3'h0 && !RX_CS_BLOCK_DONE && !RX_UB_WE &&
      !Q_LOAD |=> !IRQ)
    else $error("check failure raised the interrupt");

  chk_qload_data: assert property ( // RULE16 RULE18
    Q_LOAD |=> q.qload && q.qbuf[0] == $past({Q_ADDR_NIB, Q_CTRL_NIB}))
    else $error("subcode load not captured");

  chk_bresp_next: assert property (
    wr_fire |=> BVALID && AWREADY && WREADY)
    else $error("write answer missing");

  chk_bresp_unmapped: assert property (
    wr_fire && q.awa > `SPB_IDX_IMASK |=> BVALID && BRESP == `SPB_RESP_SLVERR)
    else $error("unmapped write not refused");

  chk_rresp_unmapped: assert property (
    rd_fire && ar_idx > `SPB_IDX_IMASK |=> RVALID && RRESP == `SPB_RESP_SLVERR)
    else $error("unmapped read not refused");

  // receiver store is kept out: it wins the same byte on purpose
  chk_rxcs_store: assert property ( // RULE6
    s_host_wr(`SPB_IDX_RXCS_END) ##0 CS_AUTOBUF && !RX_CS_WE |=>
      q.rx_cs[23] == $past(q.wd))
    else $error("receive status not written during autobuffer");

  chk_txcs_locked: assert property ( // RULE8
    s_host_wr(`SPB_IDX_TXCS) ##0 CS_AUTOBUF |=> $stable(q.tx_cs))
    else $error("transmit status written during autobuffer");

  chk_txcs_host: assert property ( // RULE8
    !CS_AUTOBUF && TX_CS_IDX == 5'h00 |=>
      TX_CS_BYTE == $past(q.tx_cs[0]))
    else $error("transmit status not taken from host buffer");

  chk_rxptr_store: assert property ( // RULE9
    s_host_wr(`SPB_IDX_RXPTR) |=> q.rx_ptr == $past(q.wd))
    else $error("receive pointer not stored");

  chk_rxub_locked: assert property ( // RULE11
    s_host_wr(`SPB_IDX_RXUB) ##0 !UB_AUTOBUF && !RX_UB_WE |=>
      $stable(q.rx_ub))
    else $error("receive user buffer written while locked");

  chk_txptr_store: assert property ( // RULE12
    s_host_wr(`SPB_IDX_TXPTR) |=> q.tx_ptr == $past(q.wd))
    else $error("transmit pointer not stored");

  // readout lags its index by one edge
  chk_txub_source: assert property ( // RULE14
    UB_AUTOBUF |=> TX_UB_BYTE == $past(q.rx_ub[TX_UB_ADDR]))
    else $error("transmit user byte not taken from receiver");

  chk_fail_clear: assert property ( // RULE15
    s_host_rd(`SPB_IDX_QSTAT) ##0 !Q_CRC_FAIL |=> !q.qfail)
    else $error("check failure flag survived its read");

  chk_qstat_read: assert property ( // RULE15 RULE16 RULE19
    s_host_rd(`SPB_IDX_QSTAT) |=>
      RDATA[7:0] == {6'h00, $past(q.qfail), $past(q.qload)})
    else $error("subcode status read back wrong");

  // a read in the same cycle clears, so it is kept out
  chk_qstat_ro: assert property ( // RULE19
    s_host_wr(`SPB_IDX_QSTAT) ##0 !Q_CRC_FAIL && !Q_LOAD && !rd_fire |=>
      $stable(q.qfail) && $stable(q.qload))
    else $error("subcode status changed by a host write");

  chk_qbuf_ro: assert property ( // RULE17
    s_host_wr(`SPB_IDX_QBUF) ##0 !Q_LOAD |=> $stable(q.qbuf))
    else $error("subcode buffer changed by a host write");

  chk_pre_read: assert property ( // RULE19
    s_host_rd(`SPB_IDX_PRE) |=> RDATA[7:0] == {4'h0, $past(q.pre)})
    else $error("preamble flags read back wrong");

endmodule // spb_top
`default_nettype wire

// ---- tb/spb_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link side: receiver decoder, subcode checker, transmitter
// ----------------------------------------------------------------
module spb_link_model
(
  // clock
  input wire logic clk,
  // receiver decoder
  output var logic [3:0] flags,
  output var logic cs_we,
  output var logic ub_we,
  output var logic [7:0] adr,
  output var logic [7:0] dat,
  output var logic [2:0] ev,
  // subcode checker
  output var logic [7:0] q_nib,
  output var logic [71:0] q_rest,
  // transmitter readout
  output var logic [4:0] cs_sel,
  output var logic [7:0] ub_sel,
  input wire logic [7:0] cs_byte,
  input wire logic [7:0] ub_byte
);
  initial
  begin
    {flags, cs_we, ub_we, adr, dat, ev} = '0;
    {q_nib, q_rest, cs_sel, ub_sel} = '0;
  end
  task automatic put(input logic ub, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk);
    cs_we <= !ub;
    ub_we <= ub;
    adr <= a;
    dat <= d;
    @(posedge clk);
    cs_we <= 1'b0;
    ub_we <= 1'b0;
    // released data lines never keep the last byte
    dat <= ~d;
  endtask
  // ev: bit 0 block done, bit 1 check fail, bit 2 subcode load
  task automatic pulse(input logic [2:0] e, input logic [79:0] q);
    @(posedge clk);
    ev <= e;
    {q_nib, q_rest} <= q;
    @(posedge clk);
    ev <= 3'h0;
    {q_nib, q_rest} <= ~q;
  endtask
  task automatic look(input logic [4:0] c, input logic [7:0] u,
    output logic [7:0] cb, output logic [7:0] ub);
    @(posedge clk);
    cs_sel <= c;
    ub_sel <= u;
    repeat (2) @(posedge clk);
    cb = cs_byte;
    ub = ub_byte;
  endtask
  task automatic set_flags(input logic [3:0] f);
    @(posedge clk);
    flags <= f;
    repeat (2) @(posedge clk);
  endtask
endmodule // spb_link_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spb_params.svh"
module tb_top;
  logic REF_CLK, RESETN, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic CS_AUTOBUF = 1'b0, UB_AUTOBUF = 1'b0;
  logic [8:0] AWADDR = 9'h000, ARADDR = 9'h000;
  logic [31:0] WDATA = 32'h0, RDATA, v;
  logic [1:0] BRESP, RRESP, r;
  logic [3:0] flags;
  logic cs_we, ub_we;
  logic [2:0] ev;
  logic [7:0] adr, dat, q_nib, ub_sel, cs_byte, ub_byte, cb, ub;
  logic [4:0] cs_sel;
  logic [71:0] q_rest;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  spb_top DUT
  (
    .REF_CLK, .RESETN,
    .AWVALID, .AWREADY, .AWADDR, .AWPROT(3'h0),
    .WVALID, .WREADY, .WDATA, .WSTRB(4'hF),
    .BVALID, .BREADY, .BRESP,
    .ARVALID, .ARREADY, .ARADDR, .ARPROT(3'h0),
    .RVALID, .RREADY, .RDATA, .RRESP,
    .IRQ, .CS_AUTOBUF, .UB_AUTOBUF,
    .SURR_CD_PREAMBLE_FLAG(flags[3]), .NONAUDIO_FRAME(flags[2]),
    .NONAUDIO_SUBFRAME_A(flags[1]), .NONAUDIO_SUBFRAME_B(flags[0]),
    .RX_CS_WE(cs_we), .RX_CS_IDX(adr[4:0]), .RX_CS_DATA(dat),
    .RX_CS_BLOCK_DONE(ev[0]),
    .RX_UB_WE(ub_we), .RX_UB_ADDR(adr), .RX_UB_DATA(dat),
    .TX_CS_IDX(cs_sel), .TX_CS_BYTE(cs_byte),
    .TX_UB_ADDR(ub_sel), .TX_UB_BYTE(ub_byte),
    .Q_LOAD(ev[2]), .Q_ADDR_NIB(q_nib[7:4]), .Q_CTRL_NIB(q_nib[3:0]),
    .Q_REST(q_rest), .Q_CRC_FAIL(ev[1])
  );
  spb_link_model lnk
  (
    .clk(REF_CLK), .flags, .cs_we, .ub_we, .adr, .dat, .ev,
    .q_nib, .q_rest, .cs_sel, .ub_sel, .cs_byte, .ub_byte
  );
  initial
  begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  task automatic complete_run();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard; the whole run needs a few hundred cycles
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // axi4-lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    @(posedge REF_CLK);
    AWVALID <= 1'b1;
    AWADDR <= {i, 2'b00};
    WVALID <= 1'b1;
    WDATA <= {24'h0, d};
    BREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] i);
    @(posedge REF_CLK);
    ARVALID <= 1'b1;
    ARADDR <= {i, 2'b00};
    RREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end
    while (!RVALID);
    v = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic rc(input logic [6:0] i, input logic [7:0] e);
    rd(i);
    check(v, {24'h0, e});
  endtask
  // irq is combinational on registers: let the last edge land first
  task automatic irq_is(input logic e);
    @(posedge REF_CLK);
    check({31'h0, IRQ}, {31'h0, e});
  endtask
  initial
  begin
    RESETN = 1'b0;
    repeat (5) @(posedge REF_CLK);
    RESETN <= 1'b1;
    for (int b = 0; b < 4; b++)
    begin
      lnk.set_flags(4'(1 << b));
      rc(`SPB_IDX_PRE, 8'(1 << b));
    end
    lnk.set_flags(4'hF);
    wr(`SPB_IDX_PRE, 8'hF0);
    rc(`SPB_IDX_PRE, 8'h0F);
    $display("flags test done");
    lnk.put(1'b0, 8'd0, 8'h03);
    lnk.put(1'b0, 8'd23, 8'hA5);
    wr(`SPB_IDX_RXCS, 8'hFF);
    rc(`SPB_IDX_RXCS, 8'h03);
    rc(`SPB_IDX_RXCS_END, 8'hA5);
    wr(`SPB_IDX_TXCS, 8'h01);
    wr(`SPB_IDX_TXCS_END, 8'h5A);
    rc(`SPB_IDX_TXCS_END, 8'h5A);
    lnk.look(5'd0, 8'd0, cb, ub);
    check(cb, 8'h01);
    CS_AUTOBUF <= 1'b1;
    wr(`SPB_IDX_RXCS_END, 8'h3C);
    rc(`SPB_IDX_RXCS_END, 8'h3C);
    wr(`SPB_IDX_TXCS, 8'hFF);
    rc(`SPB_IDX_TXCS, 8'h01);
    lnk.look(5'd0, 8'd0, cb, ub);
    check(cb, 8'h03);
    lnk.look(5'd24, 8'd0, cb, ub);
    check(cb, 8'h00);
    CS_AUTOBUF <= 1'b0;
    $display("channel status test done");
    lnk.put(1'b1, 8'hFF, 8'h6B);
    lnk.put(1'b1, 8'h07, 8'h42);
    wr(`SPB_IDX_RXPTR, 8'hFF);
    rc(`SPB_IDX_RXPTR, 8'hFF);
    wr(`SPB_IDX_RXUB, 8'h11);
    rc(`SPB_IDX_RXUB, 8'h6B);
    wr(`SPB_IDX_TXPTR, 8'h07);
    rc(`SPB_IDX_TXPTR, 8'h07);
    wr(`SPB_IDX_TXUB, 8'hC3);
    lnk.look(5'd0, 8'h07, cb, ub);
    check(ub, 8'hC3);
    UB_AUTOBUF <= 1'b1;
    wr(`SPB_IDX_RXUB, 8'h11);
    rc(`SPB_IDX_RXUB, 8'h11);
    wr(`SPB_IDX_TXUB, 8'h99);
    lnk.look(5'd0, 8'h07, cb, ub);
    check(ub, 8'h42);
    UB_AUTOBUF <= 1'b0;
    lnk.look(5'd0, 8'h07, cb, ub);
    check(ub, 8'hC3);
    $display("user buffer test done");
    wr(`SPB_IDX_IMASK, 8'h01);
    lnk.pulse(3'h4, {8'hA5, 72'h998877665544332211});
    rc(`SPB_IDX_QSTAT, 8'h01);
    irq_is(1'b1);
    wr(`SPB_IDX_QBUF, 8'h00);
    rc(`SPB_IDX_QBUF, 8'hA5);
    for (int k = 1; k < 10; k++)
      rc(7'(`SPB_IDX_QBUF + k), 8'(8'h11 * k));
    rc(`SPB_IDX_QSTAT, 8'h00);
    wr(`SPB_IDX_ISTAT, 8'h01);
    lnk.pulse(3'h2, 80'h0);
    wr(`SPB_IDX_QSTAT, 8'hFF);
    rc(`SPB_IDX_QSTAT, 8'h02);
    irq_is(1'b0);
    rc(`SPB_IDX_QSTAT, 8'h00);
    lnk.pulse(3'h1, 80'h0);
    rc(`SPB_IDX_ISTAT, 8'h06);
    irq_is(1'b0);
    wr(`SPB_IDX_IMASK, 8'h03);
    irq_is(1'b1);
    wr(`SPB_IDX_ISTAT, 8'h02);
    irq_is(1'b0);
    $display("subcode and interrupt test done");
    wr(7'h70, 8'h01);
    check(r, `SPB_RESP_SLVERR);
    rc(7'h70, 8'h00);
    check(r, `SPB_RESP_SLVERR);
    $display("unmapped test done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
